/* rtl/ctrl_xfer_pkg.sv */
// constants and types for the control-transfer decode and timing block
// assumes a byte-wide instruction stream from the prefetch queue
package ctrl_xfer_pkg;

  // opcode bytes
  localparam logic [7:0] OP_RET_NEAR = 8'hc3;
  localparam logic [7:0] OP_RET_NEAR_IMM = 8'hc2;
  localparam logic [7:0] OP_RET_FAR = 8'hcb;
  localparam logic [7:0] OP_RET_FAR_IMM = 8'hca;
  localparam logic [3:0] OP_BRANCH_HI = 4'h7;
  localparam logic [7:0] OP_COUNT_ZERO = 8'he3;
  localparam logic [7:0] OP_LOOP = 8'he2;
  localparam logic [7:0] OP_LOOP_Z = 8'he1;
  localparam logic [7:0] OP_LOOP_NZ = 8'he0;
  localparam logic [7:0] OP_ENTER = 8'hc8;
  localparam logic [7:0] OP_LEAVE = 8'hc9;
  localparam logic [7:0] OP_INT_N = 8'hcd;
  localparam logic [7:0] OP_INT3 = 8'hcc;
  localparam logic [7:0] OP_OVF_TRAP = 8'hce;
  localparam logic [7:0] OP_TRAP_EXIT = 8'hcf;
  localparam logic [7:0] OP_BOUND = 8'h62;

  // branch condition codes, low nibble of a short branch opcode
  localparam logic [3:0] COND_OVF_SET = 4'h0;
  localparam logic [3:0] COND_OVF_CLEAR = 4'h1;
  localparam logic [3:0] COND_BELOW = 4'h2;
  localparam logic [3:0] COND_NOT_BELOW = 4'h3;
  localparam logic [3:0] COND_EQUAL = 4'h4;
  localparam logic [3:0] COND_NOT_EQUAL = 4'h5;
  localparam logic [3:0] COND_BELOW_EQUAL = 4'h6;
  localparam logic [3:0] COND_ABOVE = 4'h7;
  localparam logic [3:0] COND_NEGATIVE = 4'h8;
  localparam logic [3:0] COND_POSITIVE = 4'h9;
  localparam logic [3:0] COND_PARITY_EVEN = 4'ha;
  localparam logic [3:0] COND_PARITY_ODD = 4'hb;
  localparam logic [3:0] COND_LESS = 4'hc;
  localparam logic [3:0] COND_NOT_LESS = 4'hd;
  localparam logic [3:0] COND_LESS_EQUAL = 4'he;
  localparam logic [3:0] COND_GREATER = 4'hf;

  // clock costs, wide bus (_w) and narrow bus (_n)
  localparam logic [15:0] CYC_RET_NEAR_W = 16'd16;
  localparam logic [15:0] CYC_RET_NEAR_N = 16'd20;
  localparam logic [15:0] CYC_RET_NEAR_IMM_W = 16'd18;
  localparam logic [15:0] CYC_RET_NEAR_IMM_N = 16'd22;
  localparam logic [15:0] CYC_RET_FAR_W = 16'd22;
  localparam logic [15:0] CYC_RET_FAR_N = 16'd30;
  localparam logic [15:0] CYC_RET_FAR_IMM_W = 16'd25;
  localparam logic [15:0] CYC_RET_FAR_IMM_N = 16'd33;
  localparam logic [15:0] CYC_BRANCH_NT = 16'd4;
  localparam logic [15:0] CYC_BRANCH_T = 16'd13;
  localparam logic [15:0] CYC_COUNT_ZERO_NT = 16'd5;
  localparam logic [15:0] CYC_COUNT_ZERO_T = 16'd15;
  localparam logic [15:0] CYC_LOOP_NT = 16'd6;
  localparam logic [15:0] CYC_LOOP_T = 16'd16;
  localparam logic [15:0] CYC_ENTER_L0_W = 16'd15;
  localparam logic [15:0] CYC_ENTER_L0_N = 16'd19;
  localparam logic [15:0] CYC_ENTER_L1_W = 16'd25;
  localparam logic [15:0] CYC_ENTER_L1_N = 16'd29;
  localparam logic [15:0] CYC_ENTER_LN_W = 16'd22;
  localparam logic [15:0] CYC_ENTER_LN_N = 16'd26;
  localparam logic [15:0] CYC_ENTER_STEP_W = 16'd16;
  localparam logic [15:0] CYC_ENTER_STEP_N = 16'd20;
  localparam logic [15:0] CYC_LEAVE = 16'd8;
  localparam logic [15:0] CYC_INT_N = 16'd47;
  localparam logic [15:0] CYC_INT3 = 16'd45;
  localparam logic [15:0] CYC_OVF_TRAP_T = 16'd48;
  localparam logic [15:0] CYC_OVF_TRAP_NT = 16'd4;
  localparam logic [15:0] CYC_TRAP_EXIT = 16'd28;
  localparam logic [15:0] CYC_BOUND_IN = 16'd33;
  localparam logic [15:0] CYC_BOUND_OUT = 16'd35;
  localparam logic [15:0] CYC_WORD_EXTRA = 16'd4;

  // fixed values
  localparam logic [7:0] TRAP_TYPE_INT3 = 8'h03;
  localparam logic [15:0] SHORT_LEN = 16'h0002;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OPER = 4'b0010,
    ST_CALC = 4'b0100,
    ST_EXEC = 4'b1000
  } state_t;

  typedef enum logic [4:0] {
    K_NONE, K_RET_NEAR, K_RET_NEAR_IMM, K_RET_FAR, K_RET_FAR_IMM,
    K_BRANCH, K_COUNT_ZERO, K_LOOP, K_LOOP_Z, K_LOOP_NZ,
    K_ENTER, K_LEAVE, K_INT_N, K_INT3, K_OVF_TRAP, K_TRAP_EXIT, K_BOUND
  } kind_t;

endpackage

/* rtl/branch_condition_eval.sv */
// flag test for the sixteen short conditional branches
// assumes flags are stable in the cycle they are sampled
`timescale 1ns/1ps
module branch_condition_eval
  import ctrl_xfer_pkg::*;
(
  input logic [3:0] cond,
  input logic flag_zero,
  input logic flag_carry,
  input logic flag_sign,
  input logic flag_ovf,
  input logic flag_parity,
  output logic met
);

  // signed relations, plus unsigned below-or-equal
  wire less = flag_sign ^ flag_ovf;
  wire less_eq = less | flag_zero;
  wire below_eq = flag_carry | flag_zero;

  // condition select
  assign met =
    (cond == COND_EQUAL) ? flag_zero : // RULE5
    (cond == COND_NOT_EQUAL) ? !flag_zero : // RULE5
    (cond == COND_LESS) ? less : // RULE6
    (cond == COND_NOT_LESS) ? !less : // RULE6
    (cond == COND_LESS_EQUAL) ? less_eq : // RULE6
    (cond == COND_GREATER) ? !less_eq : // RULE6
    (cond == COND_BELOW) ? flag_carry : // RULE7
    (cond == COND_NOT_BELOW) ? !flag_carry : // RULE7
    (cond == COND_BELOW_EQUAL) ? below_eq : // RULE7
    (cond == COND_ABOVE) ? !below_eq : // RULE7
    (cond == COND_PARITY_EVEN) ? flag_parity : // RULE8
    (cond == COND_PARITY_ODD) ? !flag_parity : // RULE8
    (cond == COND_OVF_SET) ? flag_ovf : // RULE8
    (cond == COND_OVF_CLEAR) ? !flag_ovf : // RULE8
    (cond == COND_NEGATIVE) ? flag_sign : // RULE8
    !flag_sign; // RULE8

endmodule // branch_condition_eval

/* rtl/control_transfer_decode_timing.sv */
// decode and execution timing of control-transfer instructions
// assumes bytes from the prefetch queue with valid/ready on clk_sys
// Contract
// RULE1: c3 is near exit, 16 clocks wide bus, 20 narrow.
// RULE2: c2 plus two immediate bytes, near exit adding immediate, 18 or 22.
// RULE3: cb far exit 22/30; ca with immediate far exit 25/33.
// RULE4: short branches take one displacement byte, cost 4 not taken, 13 taken.
// RULE5: 74 branches on zero set, 75 on zero clear.
// RULE6: 7c less, 7d not less, 7e less or equal, 7f greater.
// RULE7: 72 below, 73 not below, 76 below or equal, 77 above.
// RULE8: 7a/7b parity even/odd, 70/71 overflow set/clear, 78/79 sign set/clear.
// RULE9: e3 branches on count zero, 5 not taken, 15 taken.
// RULE10: e2 decrements count, branches while nonzero, 6 or 16 clocks.
// RULE11: e1 also needs zero set, e0 zero clear, same 6/16 cost.
// RULE12: c8 with size and level; 15/19, 25/29, then 22+16(n-1) or 26+20(n-1).
// RULE13: c9 releases the frame in 8 clocks.
// RULE14: cd typed trap 47, cc type-3 trap 45, ce overflow trap 48/4.
// RULE15: cf returns from a trap handler in 28 clocks.
// RULE16: 62 with mod-reg-r/m byte checks bounds, 33 to 35 clocks.
// RULE17: byte-timed costs gain 4 clocks per memory transfer on word operations.
// RULE18: short target is next instruction address plus sign-extended displacement.
// RULE19: loops decrement count before testing it, flags untouched.
`timescale 1ns/1ps
module control_transfer_decode_timing
  import ctrl_xfer_pkg::*;
#(
  parameter logic [7:0] OVF_TRAP_TYPE = 8'h04,
  parameter logic [7:0] BOUND_TRAP_TYPE = 8'h05
)
(
  input logic clk_sys,
  input logic rstn,
  input logic byte_valid,
  input logic [7:0] byte_data,
  input logic [15:0] byte_ip,
  output logic byte_ready,
  input logic narrow_bus,
  input logic word_op,
  input logic [3:0] mem_xfer_count,
  input logic flag_zero,
  input logic flag_carry,
  input logic flag_sign,
  input logic flag_ovf,
  input logic flag_parity,
  input logic [15:0] count_register,
  input logic [15:0] bound_index,
  input logic [15:0] bound_lower,
  input logic [15:0] bound_upper,
  output logic busy,
  output logic done,
  output logic foreign_opcode,
  output ctrl_xfer_pkg::kind_t kind,
  output logic taken,
  output logic [15:0] target,
  output logic sp_adjust_en,
  output logic [15:0] sp_adjust,
  output logic count_wr_en,
  output logic [15:0] count_wr_value,
  output logic trap_req,
  output logic [7:0] trap_type,
  output logic [15:0] frame_size,
  output logic [7:0] frame_level,
  output logic [15:0] cycles
);

  import ctrl_xfer_pkg::*;

  state_t state_reg, state_next;
  kind_t kind_reg;
  kind_t kind_dec;
  logic [3:0] cond_reg;
  logic [15:0] ip_reg;
  logic [7:0] opnd_reg [0:2];
  logic [1:0] idx_reg;
  logic [1:0] need_reg;
  logic [1:0] need_dec;
  logic [15:0] cnt_reg;
  logic ready_reg;
  logic busy_reg;
  logic done_reg;
  logic foreign_reg;
  kind_t kind_out_reg;
  logic taken_reg;
  logic [15:0] target_reg;
  logic sp_en_reg;
  logic [15:0] sp_reg;
  logic cnt_en_reg;
  logic [15:0] cnt_val_reg;
  logic trap_reg;
  logic [7:0] trap_type_reg;
  logic [15:0] frame_size_reg;
  logic [7:0] frame_level_reg;
  logic [15:0] cycles_reg;
  logic cond_met;

  // byte handshake
  wire take = byte_valid && ready_reg;
  wire in_idle = state_reg == ST_IDLE;
  wire in_calc = state_reg == ST_CALC;
  wire last_opnd = idx_reg == need_reg - 2'h1;

  // opcode decode
  assign kind_dec =
    (byte_data == OP_RET_NEAR) ? K_RET_NEAR : // RULE1
    (byte_data == OP_RET_NEAR_IMM) ? K_RET_NEAR_IMM : // RULE2
    (byte_data == OP_RET_FAR) ? K_RET_FAR : // RULE3
    (byte_data == OP_RET_FAR_IMM) ? K_RET_FAR_IMM : // RULE3
    (byte_data[7:4] == OP_BRANCH_HI) ? K_BRANCH : // RULE4
    (byte_data == OP_COUNT_ZERO) ? K_COUNT_ZERO : // RULE9
    (byte_data == OP_LOOP) ? K_LOOP : // RULE10
    (byte_data == OP_LOOP_Z) ? K_LOOP_Z : // RULE11
    (byte_data == OP_LOOP_NZ) ? K_LOOP_NZ : // RULE11
    (byte_data == OP_ENTER) ? K_ENTER : // RULE12
    (byte_data == OP_LEAVE) ? K_LEAVE : // RULE13
    (byte_data == OP_INT_N) ? K_INT_N : // RULE14
    (byte_data == OP_INT3) ? K_INT3 : // RULE14
    (byte_data == OP_OVF_TRAP) ? K_OVF_TRAP : // RULE14
    (byte_data == OP_TRAP_EXIT) ? K_TRAP_EXIT : // RULE15
    (byte_data == OP_BOUND) ? K_BOUND : // RULE16
    K_NONE;

  // operand bytes that follow each opcode
  assign need_dec =
    (kind_dec == K_RET_NEAR_IMM || kind_dec == K_RET_FAR_IMM) ? 2'h2 : // RULE2 RULE3
    (kind_dec == K_ENTER) ? 2'h3 : // RULE12
    (kind_dec == K_BRANCH || kind_dec == K_COUNT_ZERO) ? 2'h1 : // RULE4 RULE9
    (kind_dec == K_LOOP || kind_dec == K_LOOP_Z) ? 2'h1 : // RULE10 RULE11
    (kind_dec == K_LOOP_NZ || kind_dec == K_INT_N) ? 2'h1 : // RULE11 RULE14
    (kind_dec == K_BOUND) ? 2'h1 : // RULE16
    2'h0;

  // state sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take && kind_dec != K_NONE)
          state_next = (need_dec == 2'h0) ? ST_CALC : ST_OPER;
      end
      ST_OPER:
      begin
        if (take && last_opnd)
          state_next = ST_CALC;
      end
      ST_CALC:
        state_next = ST_EXEC;
      ST_EXEC:
      begin
        if (cnt_reg == 16'h0001)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // condition of the short branch
  branch_condition_eval u_cond (
    .cond(cond_reg),
    .flag_zero(flag_zero),
    .flag_carry(flag_carry),
    .flag_sign(flag_sign),
    .flag_ovf(flag_ovf),
    .flag_parity(flag_parity),
    .met(cond_met)
  );

  // operand views
  wire [15:0] imm16 = {opnd_reg[1], opnd_reg[0]};
  wire [7:0] level = opnd_reg[2];
  wire [15:0] level_m1 = {8'h00, level} - 16'h0001;
  wire [15:0] disp_sx = {{8{opnd_reg[0][7]}}, opnd_reg[0]};

  // short branch target from the following instruction address
  wire [15:0] target_calc = ip_reg + SHORT_LEN + disp_sx; // RULE18

  // count decremented ahead of the loop test, flags not written
  wire [15:0] count_dec = count_register - 16'h0001; // RULE19
  wire loop_go = count_dec != 16'h0000; // RULE19
  wire is_loop = kind_reg == K_LOOP || kind_reg == K_LOOP_Z || kind_reg == K_LOOP_NZ;

  // bounds test, signed
  wire bound_out = ($signed(bound_index) < $signed(bound_lower)) ||
    ($signed(bound_index) > $signed(bound_upper)); // RULE16

  // branch or trap outcome
  wire taken_calc =
    (kind_reg == K_BRANCH) ? cond_met : // RULE5 RULE6 RULE7 RULE8
    (kind_reg == K_COUNT_ZERO) ? (count_register == 16'h0000) : // RULE9
    (kind_reg == K_LOOP) ? loop_go : // RULE10
    (kind_reg == K_LOOP_Z) ? (loop_go && flag_zero) : // RULE11
    (kind_reg == K_LOOP_NZ) ? (loop_go && !flag_zero) : // RULE11
    (kind_reg == K_OVF_TRAP) ? flag_ovf : // RULE14
    (kind_reg == K_BOUND) ? bound_out : // RULE16
    (kind_reg == K_INT_N || kind_reg == K_INT3);

  wire trap_calc = kind_reg == K_INT_N || kind_reg == K_INT3 ||
    ((kind_reg == K_OVF_TRAP || kind_reg == K_BOUND) && taken_calc);

  wire [7:0] trap_type_calc =
    (kind_reg == K_INT_N) ? opnd_reg[0] : // RULE14
    (kind_reg == K_INT3) ? TRAP_TYPE_INT3 : // RULE14
    (kind_reg == K_OVF_TRAP) ? OVF_TRAP_TYPE : // RULE14
    BOUND_TRAP_TYPE;

  // frame entry cost by nesting level
  wire [15:0] enter_many = narrow_bus ?
    16'(CYC_ENTER_LN_N + CYC_ENTER_STEP_N * level_m1) :
    16'(CYC_ENTER_LN_W + CYC_ENTER_STEP_W * level_m1); // RULE12
  wire [15:0] enter_cost =
    (level == 8'h00) ? (narrow_bus ? CYC_ENTER_L0_N : CYC_ENTER_L0_W) : // RULE12
    (level == 8'h01) ? (narrow_bus ? CYC_ENTER_L1_N : CYC_ENTER_L1_W) : // RULE12
    enter_many; // RULE12

  // word operations pay per memory transfer on byte-timed costs
  wire [15:0] word_extra = word_op ?
    16'(CYC_WORD_EXTRA * {12'h000, mem_xfer_count}) : 16'h0000; // RULE17
  wire [15:0] bound_cost = (bound_out ? CYC_BOUND_OUT : CYC_BOUND_IN) + word_extra; // RULE16 RULE17

  // cost selection
  wire [15:0] cost_calc =
    (kind_reg == K_RET_NEAR) ? (narrow_bus ? CYC_RET_NEAR_N : CYC_RET_NEAR_W) : // RULE1
    (kind_reg == K_RET_NEAR_IMM) ? (narrow_bus ? CYC_RET_NEAR_IMM_N : CYC_RET_NEAR_IMM_W) : // RULE2
    (kind_reg == K_RET_FAR) ? (narrow_bus ? CYC_RET_FAR_N : CYC_RET_FAR_W) : // RULE3
    (kind_reg == K_RET_FAR_IMM) ? (narrow_bus ? CYC_RET_FAR_IMM_N : CYC_RET_FAR_IMM_W) : // RULE3
    (kind_reg == K_BRANCH) ? (taken_calc ? CYC_BRANCH_T : CYC_BRANCH_NT) : // RULE4
    (kind_reg == K_COUNT_ZERO) ? (taken_calc ? CYC_COUNT_ZERO_T : CYC_COUNT_ZERO_NT) : // RULE9
    is_loop ? (taken_calc ? CYC_LOOP_T : CYC_LOOP_NT) : // RULE10 RULE11
    (kind_reg == K_ENTER) ? enter_cost : // RULE12
    (kind_reg == K_LEAVE) ? CYC_LEAVE : // RULE13
    (kind_reg == K_INT_N) ? CYC_INT_N : // RULE14
    (kind_reg == K_INT3) ? CYC_INT3 : // RULE14
    (kind_reg == K_OVF_TRAP) ? (taken_calc ? CYC_OVF_TRAP_T : CYC_OVF_TRAP_NT) : // RULE14
    (kind_reg == K_TRAP_EXIT) ? CYC_TRAP_EXIT : // RULE15
    bound_cost; // RULE16

  wire is_short = kind_reg == K_BRANCH || kind_reg == K_COUNT_ZERO || is_loop;
  wire sp_calc = kind_reg == K_RET_NEAR_IMM || kind_reg == K_RET_FAR_IMM; // RULE2 RULE3

  // state, handshake and status flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      foreign_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= state_next == ST_IDLE || state_next == ST_OPER;
      busy_reg <= state_next != ST_IDLE;
      done_reg <= state_reg == ST_EXEC && cnt_reg == 16'h0001;
      foreign_reg <= in_idle && take && kind_dec == K_NONE;
    end
  end

  // opcode capture
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      kind_reg <= K_NONE;
      cond_reg <= 4'h0;
      ip_reg <= 16'h0000;
      need_reg <= 2'h0;
    end
    else if (in_idle && take && kind_dec != K_NONE)
    begin
      kind_reg <= kind_dec;
      cond_reg <= byte_data[3:0];
      ip_reg <= byte_ip;
      need_reg <= need_dec;
    end
  end

  // operand bytes, low byte first
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      idx_reg <= 2'h0;
      opnd_reg[0] <= 8'h00;
      opnd_reg[1] <= 8'h00;
      opnd_reg[2] <= 8'h00;
    end
    else if (in_idle)
      idx_reg <= 2'h0;
    else if (state_reg == ST_OPER && take)
    begin
      opnd_reg[idx_reg] <= byte_data;
      idx_reg <= idx_reg + 2'h1;
    end
  end

  // execution clock count
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= 16'h0000;
    else if (in_calc)
      cnt_reg <= cost_calc - 16'h0001;
    else if (state_reg == ST_EXEC)
      cnt_reg <= cnt_reg - 16'h0001;
  end

  // results latched when operands are complete
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      kind_out_reg <= K_NONE;
      taken_reg <= 1'b0;
      target_reg <= 16'h0000;
      trap_reg <= 1'b0;
      trap_type_reg <= 8'h00;
      cycles_reg <= 16'h0000;
    end
    else if (in_calc)
    begin
      kind_out_reg <= kind_reg;
      taken_reg <= taken_calc;
      target_reg <= is_short ? target_calc : 16'h0000; // RULE18
      trap_reg <= trap_calc;
      trap_type_reg <= trap_calc ? trap_type_calc : 8'h00;
      cycles_reg <= cost_calc;
    end
  end

  // stack, count and frame write-back values
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sp_en_reg <= 1'b0;
      sp_reg <= 16'h0000;
      cnt_en_reg <= 1'b0;
      cnt_val_reg <= 16'h0000;
      frame_size_reg <= 16'h0000;
      frame_level_reg <= 8'h00;
    end
    else if (in_calc)
    begin
      sp_en_reg <= sp_calc;
      sp_reg <= sp_calc ? imm16 : 16'h0000; // RULE2 RULE3
      cnt_en_reg <= is_loop; // RULE19
      cnt_val_reg <= is_loop ? count_dec : 16'h0000; // RULE10 RULE19
      frame_size_reg <= (kind_reg == K_ENTER) ? imm16 : 16'h0000; // RULE12
      frame_level_reg <= (kind_reg == K_ENTER) ? level : 8'h00; // RULE12
    end
  end

  // outputs straight from flops
  assign byte_ready = ready_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign foreign_opcode = foreign_reg;
  assign kind = kind_out_reg;
  assign taken = taken_reg;
  assign target = target_reg;
  assign sp_adjust_en = sp_en_reg;
  assign sp_adjust = sp_reg;
  assign count_wr_en = cnt_en_reg;
  assign count_wr_value = cnt_val_reg;
  assign trap_req = trap_reg;
  assign trap_type = trap_type_reg;
  assign frame_size = frame_size_reg;
  assign frame_level = frame_level_reg;
  assign cycles = cycles_reg;

endmodule // control_transfer_decode_timing

/* test/ctrl_xfer_props.sv */
// checker for the control-transfer decode block
// bound to the top module, sees only its ports
`timescale 1ns/1ps
module ctrl_xfer_props
  import ctrl_xfer_pkg::*;
(
  input logic clk_sys,
  input logic rstn,
  input logic byte_ready,
  input logic done,
  input logic foreign_opcode,
  input ctrl_xfer_pkg::kind_t kind,
  input logic taken,
  input logic trap_req,
  input logic [7:0] trap_type,
  input logic [15:0] cycles
);
  logic [15:0] low_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // cycles the byte link has been refused
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      low_reg <= 16'h0000;
    else
      low_reg <= byte_ready ? 16'h0000 : low_reg + 16'h0001;
  chk_done_timing: assert property (done |-> low_reg == cycles)
    else $error("done not at the reported cost");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_foreign_pulse: assert property (foreign_opcode |=> !foreign_opcode)
    else $error("foreign pulse too long");
  chk_ready_with_done: assert property (done |-> byte_ready)
    else $error("ready not back with done");
  chk_min_cost: assert property ($fell(byte_ready) |-> !done [*4])
    else $error("done before minimum cost");
  chk_branch_cost: assert property (done && kind == K_BRANCH |-> cycles == (taken ? 16'd13 : 16'd4))
    else $error("branch cost wrong");
  chk_count_zero_cost: assert property (done && kind == K_COUNT_ZERO |-> cycles == (taken ? 16'd15 : 16'd5))
    else $error("count zero cost wrong");
  chk_loop_cost: assert property (done && kind inside {K_LOOP, K_LOOP_Z, K_LOOP_NZ}
    |-> cycles == (taken ? 16'd16 : 16'd6))
    else $error("loop cost wrong");
  chk_int3_trap: assert property (done && kind == K_INT3 |-> trap_req && trap_type == 8'h03 && cycles == 16'd45)
    else $error("type 3 trap wrong");
  chk_leave_cost: assert property (done && kind == K_LEAVE |-> cycles == 16'd8)
    else $error("frame release cost wrong");
  chk_exit_cost: assert property (done && kind == K_TRAP_EXIT |-> cycles == 16'd28)
    else $error("trap exit cost wrong");
endmodule // ctrl_xfer_props

bind control_transfer_decode_timing ctrl_xfer_props ctrl_xfer_props_i (.clk_sys(clk_sys), .rstn(rstn),
  .byte_ready(byte_ready), .done(done), .foreign_opcode(foreign_opcode), .kind(kind), .taken(taken),
  .trap_req(trap_req), .trap_type(trap_type), .cycles(cycles));

/* test/prefetch_model.sv */
// byte source standing in for the prefetch queue
// offers queued bytes after falling edges and holds each until taken
`timescale 1ns/1ps
module prefetch_model
(
  input wire logic clk_sys,
  input wire logic byte_ready,
  input wire logic slow,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic [15:0] byte_ip
);
  logic [23:0] q[$];
  logic took;
  logic gap;
  task push(input logic [7:0] d, input logic [15:0] a);
    q.push_back({a, d});
  endtask
  initial
  begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    byte_ip = 16'h0000;
    took = 1'b0;
    gap = 1'b0;
  end
  // note a byte taken at this edge
  always @(posedge clk_sys)
    took = byte_valid && byte_ready;
  // hold an untaken byte, else offer the next; slow mode idles between bytes
  always @(negedge clk_sys)
  begin
    if (took)
      void'(q.pop_front());
    if (!byte_valid || took)
    begin
      gap = slow && !gap;
      if (q.size() != 0 && !gap)
      begin
        byte_valid = 1'b1;
        {byte_ip, byte_data} = q[0];
      end
      else
      begin
        byte_valid = 1'b0;
        byte_data = ~byte_data; // stale data never looks valid
        byte_ip = ~byte_ip;
      end
    end
    took = 1'b0;
  end
endmodule // prefetch_model

/* test/testbench.sv */
// self-checking bench for the control-transfer decode block
// drives inputs at falling edges; bytes come from the prefetch model
`timescale 1ns/1ps
module testbench;
  import ctrl_xfer_pkg::*;
  logic clk_sys, rstn, slow, narrow_bus, word_op, byte_valid, byte_ready, busy, done, foreign_opcode, taken;
  logic sp_adjust_en, count_wr_en, trap_req, t, inr;
  logic [3:0] mem_xfer_count;
  logic [4:0] fl;
  logic [7:0] byte_data, trap_type, frame_level, lv, d;
  logic [15:0] byte_ip, count_register, bound_index, bound_lower, bound_upper, target, sp_adjust;
  logic [15:0] count_wr_value, frame_size, cycles, pc, cyc, take_cyc, cost, imm;
  logic [31:0] seed;
  kind_t kind;
  int err_count, checks_done, j, m;
  control_transfer_decode_timing control_transfer_decode_timing_i (.clk_sys(clk_sys), .rstn(rstn),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ip(byte_ip), .byte_ready(byte_ready),
    .narrow_bus(narrow_bus), .word_op(word_op), .mem_xfer_count(mem_xfer_count), .flag_zero(fl[4]),
    .flag_carry(fl[3]), .flag_sign(fl[2]), .flag_ovf(fl[1]), .flag_parity(fl[0]),
    .count_register(count_register), .bound_index(bound_index), .bound_lower(bound_lower),
    .bound_upper(bound_upper), .busy(busy), .done(done), .foreign_opcode(foreign_opcode), .kind(kind),
    .taken(taken), .target(target), .sp_adjust_en(sp_adjust_en), .sp_adjust(sp_adjust),
    .count_wr_en(count_wr_en), .count_wr_value(count_wr_value), .trap_req(trap_req), .trap_type(trap_type),
    .frame_size(frame_size), .frame_level(frame_level), .cycles(cycles));
  prefetch_model prefetch_model_i (.clk_sys(clk_sys), .byte_ready(byte_ready), .slow(slow),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ip(byte_ip));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // edge counter and edge of the last byte taken
  always @(posedge clk_sys)
  begin
    if (byte_valid && byte_ready)
      take_cyc <= cyc;
    cyc <= cyc + 16'd1;
  end
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // new random inputs from the shift register
  task rnd;
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    {pc, fl, narrow_bus, slow, word_op, mem_xfer_count} = seed[31:4];
    {count_register, d} = {seed[23:8], seed[30:23]};
  endtask
  function logic met(input logic [3:0] c);
    logic [7:0] v;
    v = {(fl[2] ^ fl[1]) | fl[4], fl[2] ^ fl[1], fl[0], fl[2], fl[3] | fl[4], fl[4], fl[3], fl[1]};
    return v[c[3:1]] ^ c[0];
  endfunction
  // feed n bytes, wait for done, check kind, taken and timing
  task run(input logic [31:0] b, input int n, input kind_t k, input logic tk, input logic [15:0] c);
    int i;
    for (i = 0; i < n; i++)
      prefetch_model_i.push(b[8 * i +: 8], pc + i[15:0]);
    i = 0;
    do
    begin
      @(negedge clk_sys);
      i++;
    end
    while (done !== 1'b1 && i < 6000);
    cmp({busy, 10'h000, kind}, {1'b0, 10'h000, k});
    cmp(cycles, c);
    cmp(cyc - take_cyc - 16'd1, c);
    if (tk !== 1'bx)
      cmp({15'h0, taken}, {15'h0, tk});
  endtask
  initial
  begin
    #(25 * 40000);
    err_count++;
    close_out;
  end
  initial
  begin
    seed = 32'h3df01828;
    err_count = 0;
    checks_done = 0;
    cyc = 16'h0000;
    take_cyc = 16'h0000;
    rstn = 1'b0;
    rnd;
    {bound_index, bound_lower, bound_upper} = 48'h0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    // all sixteen conditions with displacement corners
    for (j = 0; j < 48; j++)
    begin
      rnd;
      d = (j < 16) ? 8'h80 : (j < 32) ? 8'h7f : d;
      t = met(j[3:0]);
      run({16'h0, d, OP_BRANCH_HI, j[3:0]}, 2, K_BRANCH, t, t ? 16'd13 : 16'd4);
      cmp(target, pc + 16'd2 + {{8{d[7]}}, d});
    end
    // count-zero branch and the three loops
    for (j = 0; j < 16; j++)
    begin
      rnd;
      m = j % 4;
      count_register = (j < 8) ? {15'h0, j[2]} : count_register;
      t = (m == 3) ? count_register == 0 : (count_register != 16'd1) && (m == 2 || fl[4] == m[0]);
      run({16'h0, d, 8'he0 | m[7:0]}, 2, m == 3 ? K_COUNT_ZERO : m == 2 ? K_LOOP : m == 1 ? K_LOOP_Z : K_LOOP_NZ,
        t, m == 3 ? (t ? 16'd15 : 16'd5) : (t ? 16'd16 : 16'd6));
      cmp(count_wr_en ? count_wr_value : 16'hbad, m != 3 ? count_register - 16'd1 : 16'hbad);
    end
    // the four exit forms, two runs each on a random bus width
    for (j = 0; j < 8; j++)
    begin
      rnd;
      m = j % 4;
      imm = seed[15:0];
      run({8'h0, imm, 8'hc3 ^ {4'h0, m[1], 2'b0, m[0]}}, m[0] ? 3 : 1,
        m == 0 ? K_RET_NEAR : m == 1 ? K_RET_NEAR_IMM : m == 2 ? K_RET_FAR : K_RET_FAR_IMM, 1'bx,
        narrow_bus ? (m == 0 ? 16'd20 : m == 1 ? 16'd22 : m == 2 ? 16'd30 : 16'd33)
        : (m == 0 ? 16'd16 : m == 1 ? 16'd18 : m == 2 ? 16'd22 : 16'd25));
      cmp(sp_adjust_en ? sp_adjust : 16'hbad, m[0] ? imm : 16'hbad);
    end
    // frame entry over nesting levels, then release
    for (j = 0; j < 10; j++)
    begin
      rnd;
      lv = (j < 2) ? 8'h00 : (j < 4) ? 8'h01 : (j < 6) ? 8'h02 : (j < 8) ? 8'h05 : 8'hff;
      cost = (lv == 0) ? (narrow_bus ? 16'd19 : 16'd15) : (lv == 1) ? (narrow_bus ? 16'd29 : 16'd25)
        : narrow_bus ? 16'd26 + 16'd20 * (lv - 16'd1) : 16'd22 + 16'd16 * (lv - 16'd1);
      run({lv, seed[15:0], OP_ENTER}, 4, K_ENTER, 1'bx, cost);
      cmp(frame_size, seed[15:0]);
      cmp({8'h0, frame_level}, {8'h0, lv});
      run({24'h0, OP_LEAVE}, 1, K_LEAVE, 1'bx, 16'd8);
    end
    // traps and trap exit
    rnd;
    run({16'h0, d, OP_INT_N}, 2, K_INT_N, 1'b1, 16'd47);
    cmp({8'h0, trap_type}, {8'h0, d});
    run({24'h0, OP_INT3}, 1, K_INT3, 1'b1, 16'd45);
    for (j = 0; j < 2; j++)
    begin
      fl[1] = j[0];
      run({24'h0, OP_OVF_TRAP}, 1, K_OVF_TRAP, j[0], j[0] ? 16'd48 : 16'd4);
      cmp({15'h0, trap_req}, {15'h0, j[0]});
    end
    run({24'h0, OP_TRAP_EXIT}, 1, K_TRAP_EXIT, 1'bx, 16'd28);
    // bounds check with edges of the range and word timing
    for (j = 0; j < 10; j++)
    begin
      rnd;
      {bound_lower, bound_upper, bound_index} = {seed[31:16], seed[31:16] + {1'b0, seed[14:0]}, count_register};
      bound_index = (j == 0) ? bound_upper : (j == 1) ? bound_lower - 16'd1 : bound_index;
      inr = $signed(bound_lower) <= $signed(bound_index) && $signed(bound_index) <= $signed(bound_upper);
      run({16'h0, d, OP_BOUND}, 2, K_BOUND, !inr,
        (inr ? 16'd33 : 16'd35) + (word_op ? 16'd4 * mem_xfer_count : 16'd0));
    end
    // an opcode from outside the group is dropped
    prefetch_model_i.push(8'h90, pc);
    t = 1'b0;
    repeat (10) @(negedge clk_sys) t = t | (foreign_opcode === 1'b1);
    cmp({15'h0, t}, 16'h1);
    close_out;
  end
endmodule // testbench
